// ### arb_pkg.sv
// Constants, register layout and types shared by the secondary bus arbiter
package arb_pkg;

  localparam int NUM_EXT = 8;
  localparam int NUM_REQ = 9;
  localparam int ADDR_W = 8;

  // Register offset (byte address); mode and priority share this word
  localparam logic [7:0] ARB_CTRL_OFFSET = 8'h48;

  // Field positions inside the arbiter control word
  localparam int EN_LSB = 0;
  localparam int EXT_ARB_BIT = 9;
  localparam int BM_TIMEOUT_EN_BIT = 10;
  localparam int BM_REFRESH_EN_BIT = 11;
  localparam int FAIR_LSB = 12;
  localparam int TOGGLE_EN_BIT = 20;
  localparam int PRIO_LSB = 22;

  // Reset values
  localparam logic [7:0] EN_RESET = 8'hFF;
  localparam logic [7:0] FAIR_RESET = 8'h08;
  localparam logic [8:0] PRIO_RESET = 9'h001;
  localparam logic BM_TIMEOUT_EN_RESET = 1'b0;
  localparam logic BM_REFRESH_EN_RESET = 1'b0;
  localparam logic TOGGLE_EN_RESET = 1'b0;

  // Timing, in bus clock cycles
  localparam logic [4:0] BM_TIMEOUT_CYCLES = 5'h10;
  localparam logic [1:0] TOGGLE_DELAY_CYCLES = 2'h2;

  localparam logic [3:0] IDX_INTERNAL = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  typedef enum {
    ST_IDLE,
    ST_WAIT,
    ST_OWN
  } arb_state_t;

  // Software-visible configuration
  typedef struct packed {
    logic [8:0] prio;
    logic toggle_en;
    logic [7:0] fair;
    logic bm_refresh_en;
    logic bm_timeout_en;
    logic [7:0] en;
  } arb_cfg_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// ### arb_input_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module arb_input_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // Filter single-cycle disagreement between the later stages
      always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          level_out[i] <= RESET_VAL[i];
        end else if (stage2[i] == stage3[i]) begin
          level_out[i] <= stage3[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### pci_secondary_bus_arbiter.sv
// Secondary PCI bus arbiter for the bridge and eight external masters
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// RULE1 - A read-only mode bit shows the strap level: low selects this arbiter, high an external one.
// RULE2 - With broken-master timeout on, count 16 bus cycles while a granted master has not started on an idle bus.
// RULE3 - When that count expires before the master starts, its grant is removed.
// RULE4 - With the timeout enable cleared, its reset state, no counting happens and no grant is revoked for not starting.
// RULE5 - Without refresh, a timed-out master is excluded for good once it has dropped its request for a clock.
// RULE6 - With refresh on, a broken master is cleared once every other master has been served once.
// RULE7 - An eight-bit fairness field, reset 08h, sets how many cycles a grant is held once another master requests.
// RULE8 - The fairness counter is reloaded from the field on every new grant.
// RULE9 - After a new grant the fairness counter is armed only by the next falling edge of the frame signal.
// RULE10 - A fairness field of 00h keeps the grant until the owner itself drops its request.
// RULE11 - With toggling on, the grant drops for one clock two clocks after the owner starts a frame; the code drops it eight clocks after the pin falls.
// RULE12 - Each requester has a priority bit, internal requester lowest and reset high, masters one to eight reset low.
// RULE13 - Each external master has an arbitration enable, and master 8 resets enabled.
// RULE14 - High-priority requests are served first, round-robin within a class, skipping disabled or broken masters.
module pci_secondary_bus_arbiter (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic arbiter_select_strap_in,
  input wire logic [7:0] ext_req_n_in,
  output logic [7:0] ext_gnt_n_out,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic internal_req_in,
  output logic internal_gnt_out,
  output logic ext_arb_req_n_out,
  input wire logic ext_arb_gnt_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out
);

  arb_pkg::arb_cfg_t cfg;
  arb_pkg::reg_req_t reg_req;
  arb_pkg::arb_state_t state;

  logic [7:0] ext_req_n_sync;
  logic frame_n_sync;
  logic irdy_n_sync;
  logic strap_sync;
  logic ext_arb_gnt_n_sync;
  logic frame_n_prev;
  logic frame_fall;
  logic bus_idle;

  logic [8:0] req_all;
  logic [8:0] en_all;
  logic [8:0] broken;
  logic [8:0] timed_out;
  logic [8:0] served;
  logic [8:0] eligible;
  logic [8:0] owner_mask;
  logic [8:0] others;
  logic [3:0] owner;
  logic [3:0] winner;
  logic any_eligible;
  logic grant_on;
  logic [7:0] fair_cnt;
  logic fair_armed;
  logic [4:0] bm_cnt;
  logic bm_expire;
  logic fair_expire;
  logic owner_drop;
  logic [1:0] tog_cnt;
  logic tog_hole;
  logic ext_mode;

  assign reg_req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // Pins come from other clock domains; the bridge request does not
  arb_input_sync #(
    .WIDTH(12),
    .RESET_VAL(12'hBFF)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .pin_in({ext_arb_gnt_n_in, strap_in_bit(arbiter_select_strap_in), irdy_n_in, frame_n_in, ext_req_n_in}),
    .level_out({ext_arb_gnt_n_sync, strap_sync, irdy_n_sync, frame_n_sync, ext_req_n_sync})
  );

  function automatic logic strap_in_bit(input logic strap);
    strap_in_bit = strap;
  endfunction

  // RULE1 strap selects arbiter
  assign ext_mode = strap_sync;

  assign req_all = {~ext_req_n_sync, internal_req_in};
  assign en_all = {cfg.en, 1'b1};
  assign bus_idle = frame_n_sync & irdy_n_sync;
  assign frame_fall = frame_n_prev & ~frame_n_sync;

  // RULE14 skip disabled or broken
  assign eligible = req_all & en_all & ~broken & ~timed_out;

  // RULE14 priority then round-robin
  function automatic logic [3:0] pick(input logic [8:0] elig, input logic [8:0] prio, input logic [3:0] last);
    logic [8:0] cand;
    logic found;
    int j;
    cand = ((elig & prio) != '0) ? (elig & prio) : elig;
    pick = last;
    found = 1'b0;
    j = 0;
    for (int k = 1; k <= arb_pkg::NUM_REQ; k++) begin
      j = (int'(last) + k) % arb_pkg::NUM_REQ;
      if (!found && cand[j]) begin
        pick = 4'(j);
        found = 1'b1;
      end
    end
  endfunction

  assign winner = pick(eligible, cfg.prio, owner);
  assign any_eligible = eligible != '0;

  genvar g;
  generate
    for (g = 0; g < arb_pkg::NUM_REQ; g++) begin : g_owner
      assign owner_mask[g] = grant_on && (owner == 4'(g));
    end
  endgenerate

  assign others = eligible & ~owner_mask;
  assign owner_drop = ~req_all[owner];

  // RULE2 bounded start window
  assign bm_expire = cfg.bm_timeout_en && (bm_cnt == arb_pkg::BM_TIMEOUT_CYCLES - 5'h01);

  // RULE7 hold after competing request
  assign fair_expire = (cfg.fair != 8'h00) && fair_armed && (others != '0) && (fair_cnt == 8'h00);

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      frame_n_prev <= 1'b1;
    end else begin
      frame_n_prev <= frame_n_sync;
    end
  end

  // Register writes
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      // RULE13 masters reset enabled
      cfg.en <= arb_pkg::EN_RESET;
      // RULE4 timeout off at reset
      cfg.bm_timeout_en <= arb_pkg::BM_TIMEOUT_EN_RESET;
      cfg.bm_refresh_en <= arb_pkg::BM_REFRESH_EN_RESET;
      // RULE7 fairness reset value
      cfg.fair <= arb_pkg::FAIR_RESET;
      cfg.toggle_en <= arb_pkg::TOGGLE_EN_RESET;
      // RULE12 internal high, rest low
      cfg.prio <= arb_pkg::PRIO_RESET;
    end else if (reg_req.wr && (reg_req.addr == arb_pkg::ARB_CTRL_OFFSET)) begin
      cfg.en <= reg_req.wdata[arb_pkg::EN_LSB +: 8];
      cfg.bm_timeout_en <= reg_req.wdata[arb_pkg::BM_TIMEOUT_EN_BIT];
      cfg.bm_refresh_en <= reg_req.wdata[arb_pkg::BM_REFRESH_EN_BIT];
      cfg.fair <= reg_req.wdata[arb_pkg::FAIR_LSB +: 8];
      cfg.toggle_en <= reg_req.wdata[arb_pkg::TOGGLE_EN_BIT];
      cfg.prio <= reg_req.wdata[arb_pkg::PRIO_LSB +: 9];
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reg_rdata_out <= arb_pkg::READ_ZERO;
    end else if (reg_req.rd && (reg_req.addr == arb_pkg::ARB_CTRL_OFFSET)) begin
      reg_rdata_out <= arb_pkg::READ_ZERO;
      reg_rdata_out[arb_pkg::EN_LSB +: 8] <= cfg.en;
      // RULE1 strap shown read-only
      reg_rdata_out[arb_pkg::EXT_ARB_BIT] <= strap_sync;
      reg_rdata_out[arb_pkg::BM_TIMEOUT_EN_BIT] <= cfg.bm_timeout_en;
      reg_rdata_out[arb_pkg::BM_REFRESH_EN_BIT] <= cfg.bm_refresh_en;
      reg_rdata_out[arb_pkg::FAIR_LSB +: 8] <= cfg.fair;
      reg_rdata_out[arb_pkg::TOGGLE_EN_BIT] <= cfg.toggle_en;
      reg_rdata_out[arb_pkg::PRIO_LSB +: 9] <= cfg.prio;
    end else begin
      reg_rdata_out <= arb_pkg::READ_ZERO;
    end
  end

  // Grant state machine
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= arb_pkg::ST_IDLE;
      owner <= arb_pkg::IDX_INTERNAL;
      grant_on <= 1'b0;
    end else if (ext_mode) begin
      state <= arb_pkg::ST_IDLE;
      grant_on <= 1'b0;
    end else begin
      unique case (state)
        arb_pkg::ST_IDLE: begin
          if (any_eligible) begin
            owner <= winner;
            grant_on <= 1'b1;
            state <= arb_pkg::ST_WAIT;
          end
        end
        arb_pkg::ST_WAIT: begin
          if (frame_fall) begin
            state <= arb_pkg::ST_OWN;
          // RULE3 revoke on timeout
          end else if ((bm_expire && owner != arb_pkg::IDX_INTERNAL) || owner_drop) begin
            grant_on <= 1'b0;
            state <= arb_pkg::ST_IDLE;
          end
        end
        arb_pkg::ST_OWN: begin
          // RULE10 zero field waits for owner
          if (owner_drop || fair_expire) begin
            grant_on <= 1'b0;
            state <= arb_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Broken-master start counter
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bm_cnt <= 5'h00;
    end else if (state != arb_pkg::ST_WAIT || !cfg.bm_timeout_en) begin
      // RULE4 no counting when disabled
      bm_cnt <= 5'h00;
    end else if (bus_idle && frame_n_sync) begin
      // RULE2 count idle cycles
      bm_cnt <= bm_cnt + 5'h01;
    end
  end

  // Broken state, served history and refresh
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      timed_out <= '0;
      broken <= '0;
      served <= '0;
    end else begin
      // RULE6 refresh after round served
      if (cfg.bm_refresh_en && ((broken | timed_out) != '0) && ((served | broken | timed_out | ~en_all) == '1)) begin
        timed_out <= '0;
        broken <= '0;
        served <= '0;
      end else begin
        if (state == arb_pkg::ST_WAIT && bm_expire && owner != arb_pkg::IDX_INTERNAL) begin
          timed_out[owner] <= 1'b1;
        end
        // RULE5 excluded once request drops
        broken <= broken | (timed_out & ~req_all);
        if (state == arb_pkg::ST_IDLE && any_eligible && !ext_mode) begin
          served[winner] <= 1'b1;
        end
      end
    end
  end

  // Fairness counter
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fair_cnt <= arb_pkg::FAIR_RESET;
      fair_armed <= 1'b0;
    end else if (state == arb_pkg::ST_IDLE) begin
      // RULE8 reload on new grant
      fair_cnt <= cfg.fair;
      fair_armed <= 1'b0;
    end else begin
      // RULE9 armed by frame fall
      if (frame_fall) begin
        fair_armed <= 1'b1;
      end
      // RULE7 count while others wait
      if (fair_armed && (others != '0) && (fair_cnt != 8'h00)) begin
        fair_cnt <= fair_cnt - 8'h01;
      end
    end
  end

  // Grant toggle timer, started by the owner's frame
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tog_cnt <= 2'h0;
      tog_hole <= 1'b0;
    end else begin
      // RULE11 one-clock gap after two
      tog_hole <= cfg.toggle_en && (tog_cnt == 2'h1);
      if (frame_fall && grant_on && cfg.toggle_en) begin
        tog_cnt <= arb_pkg::TOGGLE_DELAY_CYCLES;
      end else if (tog_cnt != 2'h0) begin
        tog_cnt <= tog_cnt - 2'h1;
      end
    end
  end

  // Registered pin outputs; grants are active low on the bus
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_gnt_n_out <= 8'hFF;
      internal_gnt_out <= 1'b0;
      ext_arb_req_n_out <= 1'b1;
    end else if (ext_mode) begin
      // Bridge becomes an ordinary requester of the outside arbiter
      ext_gnt_n_out <= 8'hFF;
      internal_gnt_out <= ~ext_arb_gnt_n_sync;
      ext_arb_req_n_out <= ~internal_req_in;
    end else begin
      ext_gnt_n_out <= ~(owner_mask[8:1] & {8{~tog_hole}});
      internal_gnt_out <= owner_mask[0] & ~tog_hole;
      ext_arb_req_n_out <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### pci_secondary_bus_arbiter_sva.sv
// Port-level checks for the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none
module pci_secondary_bus_arbiter_chk (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic arbiter_select_strap_in,
  input wire logic [7:0] ext_req_n_in,
  input wire logic [7:0] ext_gnt_n_out,
  input wire logic frame_n_in,
  input wire logic irdy_n_in,
  input wire logic internal_req_in,
  input wire logic internal_gnt_out,
  input wire logic ext_arb_req_n_out,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic [31:0] reg_rdata_out
);
  // Shadow of the control word, snooped from writes
  logic [31:0] cfg;
  logic [7:0] en;
  logic [7:0] idle_cnt;
  logic hold_mode;
  assign en = cfg[7:0];
  assign hold_mode = cfg[19:12] == 8'h00 && !cfg[10] && !cfg[20];
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg <= 32'h0040_80FF;
    end else if (reg_wr_in && reg_addr_in == arb_pkg::ARB_CTRL_OFFSET) begin
      cfg <= reg_wdata_in;
    end
  end
  // Idle bus cycles under an external grant; a frame or a gap restarts it
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      idle_cnt <= 8'h00;
    end else if (&ext_gnt_n_out || !frame_n_in || !irdy_n_in) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'hFF) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_single_grant: assert property ($onehot0({~ext_gnt_n_out, internal_gnt_out}))
    else $error("two grants at once");
  a_int_grant_cause: assert property ($rose(internal_gnt_out) |-> $past(internal_req_in, 2))
    else $error("internal grant without request");
  a_disabled_skip: assert property ((~ext_gnt_n_out & $past(ext_gnt_n_out)
    & ~(en | $past(en) | $past(en, 2) | $past(en, 3))) == 8'h00) else $error("disabled master granted");
  a_fair_zero_hold: assert property (hold_mode |-> (ext_gnt_n_out & ~$past(ext_gnt_n_out) & ~($past(ext_req_n_in, 3)
    | $past(ext_req_n_in, 4) | $past(ext_req_n_in, 5) | $past(ext_req_n_in, 6) | $past(ext_req_n_in, 7)
    | $past(ext_req_n_in, 8))) == 8'h00) else $error("grant removed while still requested");
  a_timeout_bound: assert property (cfg[10] |-> idle_cnt <= 8'h14)
    else $error("idle grant not revoked");
  a_ext_mode_quiet: assert property (arbiter_select_strap_in && $past(arbiter_select_strap_in, 8) |-> &ext_gnt_n_out)
    else $error("grant in external mode");
  a_int_mode_local: assert property (!arbiter_select_strap_in && !$past(arbiter_select_strap_in, 8) |-> ext_arb_req_n_out)
    else $error("outside request in internal mode");
  a_reserved_zero: assert property (reg_rdata_out[31] == 1'b0 && reg_rdata_out[21] == 1'b0 && reg_rdata_out[8] == 1'b0)
    else $error("reserved bit set");
endmodule
bind pci_secondary_bus_arbiter pci_secondary_bus_arbiter_chk u_chk (.core_clk_in, .reset_n_in,
  .arbiter_select_strap_in, .ext_req_n_in, .ext_gnt_n_out, .frame_n_in, .irdy_n_in, .internal_req_in,
  .internal_gnt_out, .ext_arb_req_n_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rdata_out);
`default_nettype wire

// ### pci_bus_masters.sv
// Behavioural model of the eight requesting bus masters
`timescale 1ns/1ps
`default_nettype none
module pci_bus_masters (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] want_in,
  input wire logic [7:0] broken_in,
  input wire logic [7:0] gnt_n_in,
  output logic [7:0] req_n_out,
  output logic frame_n_out,
  output logic irdy_n_out
);
  logic [2:0] len;
  // Lines idle high as with the bus pull-ups; a broken master never starts
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      req_n_out <= 8'hFF;
      frame_n_out <= 1'b1;
      irdy_n_out <= 1'b1;
      len <= 3'h0;
    end else begin
      req_n_out <= ~want_in;
      if (len != 3'h0) begin
        len <= len - 3'h1;
        frame_n_out <= len <= 3'h2;
        irdy_n_out <= len == 3'h1;
      end else if (frame_n_out && irdy_n_out && |(~gnt_n_in & want_in & ~broken_in)) begin
        len <= 3'h6;
        frame_n_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### pci_secondary_bus_arbiter_tb.sv
// Self-checking bench for the secondary bus arbiter
`timescale 1ns/1ps
`default_nettype none
module pci_secondary_bus_arbiter_tb;
  localparam logic [7:0] A = arb_pkg::ARB_CTRL_OFFSET;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic int_req = 1'b0;
  logic ext_gnt_n = 1'b1;
  logic arb_req_n;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] want = 8'h00;
  logic [7:0] broken = 8'h00;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [7:0] req_n;
  logic [7:0] gnt_n;
  logic frame_n;
  logic irdy_n;
  logic int_gnt;
  logic [31:0] rdata;
  logic [8:0] gv;
  logic [8:0] gv_prev = 9'h000;
  logic [31:0] rq[$];
  logic [8:0] gq[$];
  int failures = 0;
  int check_count = 0;
  assign gv = {~gnt_n, int_gnt};
  always #4 clk = ~clk;
  pci_secondary_bus_arbiter u_pci_secondary_bus_arbiter (.core_clk_in(clk), .reset_n_in(rst_n),
    .arbiter_select_strap_in(strap), .ext_req_n_in(req_n), .ext_gnt_n_out(gnt_n), .frame_n_in(frame_n),
    .irdy_n_in(irdy_n), .internal_req_in(int_req), .internal_gnt_out(int_gnt), .ext_arb_req_n_out(arb_req_n),
    .ext_arb_gnt_n_in(ext_gnt_n), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata));
  pci_bus_masters u_pci_bus_masters (.clk_in(clk), .reset_n_in(rst_n), .want_in(want), .broken_in(broken),
    .gnt_n_in(gnt_n), .req_n_out(req_n), .frame_n_out(frame_n), .irdy_n_out(irdy_n));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [7:0] en, input logic tmo, input logic [7:0] fair,
    input logic tog, input logic [8:0] prio);
    return {1'b0, prio, 1'b0, tog, fair, 1'b0, tmo, 2'b00, en};
  endfunction
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Read data and first grant after an all-idle gap are matched to the oldest note
  always @(posedge clk) begin
    if (rd_seen) begin
      chk(rdata, rq.pop_front());
    end
    if (gv_prev === 9'h000 && gv !== 9'h000 && gq.size() > 0) begin
      chk(32'(gv), 32'(gq.pop_front()));
    end
    rd_seen <= rd;
    gv_prev <= gv;
  end
  // The scenarios take under a thousand cycles; this is far beyond
  initial begin
    #160000;
    failures++;
    wrap_up();
  end
  initial begin
    int n;
    logic [31:0] d;
    void'($urandom(32'h67f6));
    idle(12);
    rst_n <= 1'b1;
    idle(6);
    rd_reg(A, 32'h0040_80FF);
    rd_reg(8'h4C, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      d = $urandom;
      wr_reg(A, d);
      rd_reg(A, d & 32'h7FDF_FCFF);
    end
    for (int k = 0; k < 2; k++) begin
      wr_reg(A, cfg(8'hFF, 1'b0, 8'h08, 1'b0, k ? 9'h002 : 9'h008));
      gq.push_back(k ? 9'h002 : 9'h008);
      want <= 8'h05;
      idle(30);
      want <= 8'h00;
      idle(12);
    end
    int_req <= 1'b1;
    gq.push_back(9'h001);
    idle(10);
    int_req <= 1'b0;
    wr_reg(A, cfg(8'hFD, 1'b0, 8'h08, 1'b0, 9'h001));
    want <= 8'h02;
    idle(30);
    chk(32'(gv[2]), 32'h0);
    want <= 8'h00;
    idle(12);
    wr_reg(A, cfg(8'hFF, 1'b0, 8'h04, 1'b0, 9'h001));
    gq.push_back(9'h002);
    gq.push_back(9'h004);
    want <= 8'h01;
    idle(15);
    want <= 8'h03;
    idle(40);
    chk(32'(gq.size()), 32'h0);
    want <= 8'h00;
    idle(12);
    wr_reg(A, cfg(8'hFF, 1'b0, 8'h00, 1'b0, 9'h001));
    gq.push_back(9'h002);
    want <= 8'h01;
    idle(15);
    want <= 8'h03;
    idle(60);
    chk(32'(gv), 32'h0000_0004 >> 1);
    gq.push_back(9'h004);
    want <= 8'h02;
    idle(20);
    broken <= 8'h04;
    want <= 8'h04;
    idle(40);
    chk(32'(gv[3]), 32'h1);
    want <= 8'h00;
    idle(12);
    wr_reg(A, cfg(8'hFF, 1'b1, 8'h00, 1'b0, 9'h001));
    want <= 8'h04;
    n = 0;
    while (gv[3] !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (gv[3] === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n >= 14 && n <= 18), 32'h1);
    want <= 8'h00;
    idle(3);
    want <= 8'h04;
    idle(40);
    chk(32'(gv[3]), 32'h0);
    gq.push_back(9'h002);
    want <= 8'h05;
    idle(20);
    want <= 8'h00;
    broken <= 8'h00;
    idle(12);
    wr_reg(A, cfg(8'hFF, 1'b0, 8'h00, 1'b1, 9'h001));
    want <= 8'h01;
    n = 0;
    while (frame_n !== 1'b0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    repeat (10) begin
      @(posedge clk);
      if (gv[1] !== 1'b1) n++;
    end
    chk(32'(n), 32'h1);
    want <= 8'h00;
    idle(12);
    strap <= 1'b1;
    idle(8);
    rd_reg(A, cfg(8'hFF, 1'b0, 8'h00, 1'b1, 9'h001) | 32'h0000_0200);
    want <= 8'h01;
    idle(30);
    chk(32'(gv[8:1]), 32'h0);
    want <= 8'h00;
    int_req <= 1'b1;
    idle(6);
    chk(32'(arb_req_n), 32'h0);
    ext_gnt_n <= 1'b0;
    idle(8);
    chk(32'(int_gnt), 32'h1);
    int_req <= 1'b0;
    ext_gnt_n <= 1'b1;
    idle(8);
    chk(32'({arb_req_n, int_gnt}), 32'h2);
    wrap_up();
  end
endmodule
`default_nettype wire
